// ### include/ebce_defines.vh
// Constants for the external bus cycle engine.
`ifndef EBCE_DEFINES_VH
`define EBCE_DEFINES_VH

// ----------------------------------------------------------------------------
// Transfer size codes; port size codes share the same encoding.
// ----------------------------------------------------------------------------
`define EBCE_SIZ_LONG 2'h0
`define EBCE_SIZ_BYTE 2'h1
`define EBCE_SIZ_WORD 2'h2
`define EBCE_SIZ_LINE 2'h3

// ----------------------------------------------------------------------------
// Window configuration field layout, one slice per window.
// ----------------------------------------------------------------------------
`define EBCE_CFG_W        10
`define EBCE_CFG_PORT_LO  0
`define EBCE_CFG_PORT_HI  1
`define EBCE_CFG_WAIT_LO  2
`define EBCE_CFG_WAIT_HI  5
`define EBCE_CFG_AUTO_ACK 6
`define EBCE_CFG_BST_RD   7
`define EBCE_CFG_BST_WR   8
`define EBCE_CFG_VALID    9
`define EBCE_BASE_W       16
`define EBCE_NUM_CS       8
`define EBCE_NUM_WIN      10

// ----------------------------------------------------------------------------
// Byte lane enables, bit 0 is the most significant lane.
// ----------------------------------------------------------------------------
`define EBCE_LANES_ALL  4'hf
`define EBCE_LANES_TOP  4'h1
`define EBCE_LANES_HIGH 4'h3
`define EBCE_LANES_LOW  4'hc
`define EBCE_LANES_NONE 4'h0

`endif

// ### core/ebce_engine.v
// External bus cycle engine: window decode, cycle state machine and sizing.
`timescale 1ns/100ps
// Behaviour
// - Address, write data, start and attributes change only on bus clock rising edges.
// - Strobe, selects, output enable and byte enables change only on falling edges.
// - Burst to a smaller port keeps the whole transfer size code throughout.
// - Burst-inhibited: first access shows transfer size, later ones show port size.
// - Size code: 00 longword, 01 byte, 10 word, 11 line.
// - 8-bit port uses top lane; longword goes as four bytes, MSB first.
// - Compare address with eight select and two DRAM windows; single match uses its setup.
// - No match: burst-inhibited, externally terminated 32-bit cycle.
// - Several select matches: drive all, still inhibited, external, 32-bit.
// - Both DRAM windows, or DRAM plus select, matching gives undefined behaviour.
// - Read data is sampled with the acknowledge at the rising edge.
// - Write data driven from the end of the first clock to the cycle end.
// - Acknowledge missing at end of second clock inserts whole-clock wait states.
// - Final clock holds address, attributes and write data; basic cycle is three clocks.
// - Each bus clock splits in two states: even high, odd low.
// - Start edge drives address, in-progress, read/write, type, modifier, size, start.
// - Next falling edge asserts strobe, select, byte enables and, on reads only, output enable.
// - Acknowledge in the first low phase gives fast termination, skipping two states.
// - Entering the second high state negates start; a write drives data.
// - Final state negates strobes on falling edge, releases attributes on rising edge.
`include "ebce_defines.vh"

module ebce_engine #(
  parameter NUM_CS  = `EBCE_NUM_CS,
  parameter NUM_WIN = `EBCE_NUM_WIN
) (
  input  wire                              i_core_clk,
  input  wire                              i_reset,
  input  wire                              i_req,
  input  wire [31:0]                       i_req_addr,
  input  wire                              i_req_write,
  input  wire [1:0]                        i_req_size,
  input  wire [1:0]                        i_req_type,
  input  wire [2:0]                        i_req_modifier,
  input  wire [31:0]                       i_req_wdata,
  input  wire [NUM_WIN*`EBCE_BASE_W-1:0]   i_win_base,
  input  wire [NUM_WIN*`EBCE_BASE_W-1:0]   i_win_mask,
  input  wire [NUM_WIN*`EBCE_CFG_W-1:0]    i_win_cfg,
  input  wire                              i_transfer_ack_n,
  input  wire [31:0]                       i_data_in,
  output reg                               o_req_ready,
  output reg                               o_done,
  output reg  [31:0]                       o_rdata,
  output reg                               o_bus_input_clock,
  output reg  [31:0]                       o_addr,
  output reg                               o_addr_oe,
  output reg                               o_read_write,
  output reg  [1:0]                        o_transfer_size_code,
  output reg  [1:0]                        o_transfer_type,
  output reg  [2:0]                        o_transfer_modifier,
  output reg                               o_transfer_start_n,
  output reg                               o_transfer_in_progress_n,
  output reg  [31:0]                       o_data_out,
  output reg                               o_data_oe,
  output reg                               o_addr_strobe_n,
  output reg  [NUM_CS-1:0]                 o_chip_select_n,
  output reg  [NUM_WIN-NUM_CS-1:0]         o_dram_select,
  output reg  [3:0]                        o_byte_lane_enable_n,
  output reg                               o_output_enable_n
);

  // --------------------------------------------------------------------------
  // States; even codes are high-phase states, odd codes other than ST_IDLE low-phase states.
  // --------------------------------------------------------------------------
  localparam [2:0] ST_START_HIGH   = 3'h0;
  localparam [2:0] ST_STROBE_LOW   = 3'h1;
  localparam [2:0] ST_SECOND_HIGH  = 3'h2;
  localparam [2:0] ST_WAIT_LOW     = 3'h3;
  localparam [2:0] ST_SAMPLED_HIGH = 3'h4;
  localparam [2:0] ST_END_LOW      = 3'h5;
  localparam [2:0] ST_IDLE         = 3'h7;

  // --------------------------------------------------------------------------
  // Window decode.
  // --------------------------------------------------------------------------
  wire [NUM_WIN-1:0] hit;
  genvar gi;
  generate
    for (gi = 0; gi < NUM_WIN; gi = gi + 1) begin : g_win
      wire [`EBCE_BASE_W-1:0] base_w = i_win_base[gi*`EBCE_BASE_W +: `EBCE_BASE_W];
      wire [`EBCE_BASE_W-1:0] mask_w = i_win_mask[gi*`EBCE_BASE_W +: `EBCE_BASE_W];
      assign hit[gi] = i_win_cfg[gi*`EBCE_CFG_W + `EBCE_CFG_VALID] &&
                       (((i_req_addr[31:16] ^ base_w) & ~mask_w) == {`EBCE_BASE_W{1'b0}});
    end
  endgenerate

  wire [NUM_CS-1:0]         cs_hit   = hit[NUM_CS-1:0];
  wire [NUM_WIN-NUM_CS-1:0] dram_hit = hit[NUM_WIN-1:NUM_CS];
  wire                      cs_multi = (cs_hit & (cs_hit - 1'b1)) != {NUM_CS{1'b0}};

  reg  [`EBCE_CFG_W-1:0] sel_cfg;
  reg                    sel_own;
  integer                k;

  // A DRAM hit takes priority; mixed hits are undefined, so any choice is legal.
  always @* begin
    sel_cfg = {`EBCE_CFG_W{1'b0}};
    sel_own = 1'b0;
    for (k = 0; k < NUM_WIN; k = k + 1) begin
      if (hit[k] && !(k < NUM_CS && cs_multi)) begin
        sel_cfg = i_win_cfg[k*`EBCE_CFG_W +: `EBCE_CFG_W];
        sel_own = 1'b1;
      end
    end
  end

  // No usable single window: external, inhibited, 32-bit.
  wire [1:0] new_port  = sel_own ? sel_cfg[`EBCE_CFG_PORT_HI:`EBCE_CFG_PORT_LO] : `EBCE_SIZ_LONG;
  wire       new_auto  = sel_own & sel_cfg[`EBCE_CFG_AUTO_ACK];
  wire       new_burst = sel_own & (i_req_write ? sel_cfg[`EBCE_CFG_BST_WR] : sel_cfg[`EBCE_CFG_BST_RD]);
  wire [3:0] new_waits = sel_own ? sel_cfg[`EBCE_CFG_WAIT_HI:`EBCE_CFG_WAIT_LO] : 4'h0;

  // Number of port accesses needed for the whole transfer.
  reg [4:0] total_bytes;
  reg [4:0] new_beats;
  always @* begin
    case (i_req_size)
      `EBCE_SIZ_BYTE: total_bytes = 5'h01;
      `EBCE_SIZ_WORD: total_bytes = 5'h02;
      `EBCE_SIZ_LINE: total_bytes = 5'h10;
      default:        total_bytes = 5'h04;
    endcase
    case (new_port)
      `EBCE_SIZ_BYTE: new_beats = total_bytes;
      `EBCE_SIZ_WORD: new_beats = (total_bytes > 5'h02) ? (total_bytes >> 1) : 5'h01;
      default:        new_beats = (total_bytes > 5'h04) ? (total_bytes >> 2) : 5'h01;
    endcase
  end

  // --------------------------------------------------------------------------
  // Held transfer context.
  // --------------------------------------------------------------------------
  reg [2:0]              st_q;
  reg [1:0]              port_q;
  reg                    auto_q;
  reg                    burst_q;
  reg [3:0]              waits_q;
  reg [3:0]              wcnt_q;
  reg [4:0]              beats_q;
  reg                    write_q;
  reg [NUM_CS-1:0]       cs_q;
  reg [NUM_WIN-NUM_CS-1:0] dram_q;
  reg [31:0]             rd_q;

  // Byte lanes for the current access; the top lane is lane bit 0.
  reg [3:0] lanes;
  always @* begin
    case (port_q)
      `EBCE_SIZ_BYTE: lanes = `EBCE_LANES_TOP;
      `EBCE_SIZ_WORD: lanes = `EBCE_LANES_HIGH;
      default: begin
        case (o_transfer_size_code)
          `EBCE_SIZ_BYTE: lanes = `EBCE_LANES_TOP << o_addr[1:0];
          `EBCE_SIZ_WORD: lanes = o_addr[1] ? `EBCE_LANES_LOW : `EBCE_LANES_HIGH;
          default:        lanes = `EBCE_LANES_ALL;
        endcase
      end
    endcase
  end

  // Read data gathered lane by lane, most significant part first.
  reg [31:0] rd_next;
  always @* begin
    case (port_q)
      `EBCE_SIZ_BYTE: rd_next = {rd_q[23:0], i_data_in[31:24]};
      `EBCE_SIZ_WORD: rd_next = {rd_q[15:0], i_data_in[31:16]};
      default:        rd_next = i_data_in;
    endcase
  end

  wire [5:0] step = (port_q == `EBCE_SIZ_BYTE) ? 6'h08 : (port_q == `EBCE_SIZ_WORD) ? 6'h10 : 6'h00;
  wire [3:0] step_bytes = (port_q == `EBCE_SIZ_BYTE) ? 4'h1 : (port_q == `EBCE_SIZ_WORD) ? 4'h2 : 4'h4;
  wire       ext_ack = !auto_q && !i_transfer_ack_n;
  wire       int_ack = auto_q && (wcnt_q == 4'h0);

  // --------------------------------------------------------------------------
  // Cycle state machine; each core clock edge is one half bus clock.
  // --------------------------------------------------------------------------
  always @(posedge i_core_clk) begin
    if (i_reset) begin
      st_q                     <= ST_IDLE;
      o_bus_input_clock        <= 1'b0;
      port_q                   <= `EBCE_SIZ_LONG;
      auto_q                   <= 1'b0;
      burst_q                  <= 1'b0;
      waits_q                  <= 4'h0;
      wcnt_q                   <= 4'h0;
      beats_q                  <= 5'h00;
      write_q                  <= 1'b0;
      cs_q                     <= {NUM_CS{1'b0}};
      dram_q                   <= {(NUM_WIN-NUM_CS){1'b0}};
      rd_q                     <= 32'h0;
      o_req_ready              <= 1'b0;
      o_done                   <= 1'b0;
      o_rdata                  <= 32'h0;
      o_addr                   <= 32'h0;
      o_addr_oe                <= 1'b0;
      o_read_write             <= 1'b1;
      o_transfer_size_code     <= `EBCE_SIZ_LONG;
      o_transfer_type          <= 2'h0;
      o_transfer_modifier      <= 3'h0;
      o_transfer_start_n       <= 1'b1;
      o_transfer_in_progress_n <= 1'b1;
      o_data_out               <= 32'h0;
      o_data_oe                <= 1'b0;
      o_addr_strobe_n          <= 1'b1;
      o_chip_select_n          <= {NUM_CS{1'b1}};
      o_dram_select            <= {(NUM_WIN-NUM_CS){1'b0}};
      o_byte_lane_enable_n     <= {4{1'b1}};
      o_output_enable_n        <= 1'b1;
    end else begin
      o_bus_input_clock <= ~o_bus_input_clock;
      o_done            <= 1'b0;
      case (st_q)
        ST_IDLE: begin
          // Starts only on an edge that raises the bus clock.
          o_req_ready <= o_bus_input_clock;
          if (i_req && o_req_ready && !o_bus_input_clock) begin
            o_req_ready              <= 1'b0;
            st_q                     <= ST_START_HIGH;
            port_q                   <= new_port;
            auto_q                   <= new_auto;
            burst_q                  <= new_burst && !cs_multi;
            waits_q                  <= new_waits;
            wcnt_q                   <= new_waits;
            beats_q                  <= new_beats;
            write_q                  <= i_req_write;
            cs_q                     <= cs_hit;
            dram_q                   <= dram_hit;
            rd_q                     <= 32'h0;
            o_addr                   <= i_req_addr;
            o_addr_oe                <= 1'b1;
            o_read_write             <= !i_req_write;
            o_transfer_size_code     <= i_req_size;
            o_transfer_type          <= i_req_type;
            o_transfer_modifier      <= i_req_modifier;
            o_transfer_start_n       <= 1'b0;
            o_transfer_in_progress_n <= 1'b0;
            o_data_out               <= i_req_wdata;
          end
        end
        ST_START_HIGH: begin
          st_q                 <= ST_STROBE_LOW;
          o_addr_strobe_n      <= 1'b0;
          o_chip_select_n      <= ~cs_q;
          o_dram_select        <= dram_q;
          o_byte_lane_enable_n <= ~lanes;
          o_output_enable_n    <= write_q;
        end
        ST_STROBE_LOW: begin
          o_transfer_start_n <= 1'b1;
          o_data_oe          <= write_q;
          if (ext_ack) begin
            st_q <= ST_SAMPLED_HIGH;
            rd_q <= rd_next;
          end else begin
            st_q <= ST_SECOND_HIGH;
          end
        end
        ST_SECOND_HIGH: begin
          st_q <= ST_WAIT_LOW;
        end
        ST_WAIT_LOW: begin
          if (ext_ack || int_ack) begin
            st_q <= ST_SAMPLED_HIGH;
            rd_q <= rd_next;
          end else begin
            st_q   <= ST_SECOND_HIGH;
            wcnt_q <= wcnt_q - 4'h1;
          end
        end
        ST_SAMPLED_HIGH: begin
          st_q                 <= ST_END_LOW;
          o_addr_strobe_n      <= 1'b1;
          o_chip_select_n      <= {NUM_CS{1'b1}};
          o_dram_select        <= {(NUM_WIN-NUM_CS){1'b0}};
          o_byte_lane_enable_n <= {4{1'b1}};
          o_output_enable_n    <= 1'b1;
        end
        ST_END_LOW: begin
          if (beats_q > 5'h01) begin
            // Back-to-back access; in-progress stays asserted.
            st_q               <= ST_START_HIGH;
            beats_q            <= beats_q - 5'h01;
            wcnt_q             <= waits_q;
            o_transfer_start_n <= 1'b0;
            o_data_oe          <= 1'b0;
            o_addr             <= o_addr + {28'h0, step_bytes};
            o_data_out         <= o_data_out << step;
            if (!burst_q) begin
              o_transfer_size_code <= port_q;
            end
          end else begin
            // Hold clock ends here: release address, attributes, in-progress and data drive together.
            st_q                     <= ST_IDLE;
            o_addr_oe                <= 1'b0;
            o_read_write             <= 1'b1;
            o_transfer_size_code     <= `EBCE_SIZ_LONG;
            o_transfer_type          <= 2'h0;
            o_transfer_modifier      <= 3'h0;
            o_transfer_in_progress_n <= 1'b1;
            o_data_oe                <= 1'b0;
            o_done                   <= 1'b1;
            o_rdata                  <= rd_q;
          end
        end
        default: begin
          st_q <= ST_IDLE;
        end
      endcase
    end
  end

endmodule // ebce_engine

// ### tb/ebce_engine_chk.sv
// Concurrent checks on the bus cycle engine ports.
`timescale 1ns/100ps

module ebce_engine_chk #(
  parameter NUM_CS  = 8,
  parameter NUM_WIN = 10
) (
  input logic                      i_core_clk,
  input logic                      i_reset,
  input logic                      i_transfer_ack_n,
  input logic                      o_req_ready,
  input logic                      o_done,
  input logic                      o_bus_input_clock,
  input logic [31:0]               o_addr,
  input logic                      o_addr_oe,
  input logic                      o_read_write,
  input logic [1:0]                o_transfer_size_code,
  input logic [1:0]                o_transfer_type,
  input logic [2:0]                o_transfer_modifier,
  input logic                      o_transfer_start_n,
  input logic                      o_transfer_in_progress_n,
  input logic [31:0]               o_data_out,
  input logic                      o_data_oe,
  input logic                      o_addr_strobe_n,
  input logic [NUM_CS-1:0]         o_chip_select_n,
  input logic [NUM_WIN-NUM_CS-1:0] o_dram_select,
  input logic [3:0]                o_byte_lane_enable_n,
  input logic                      o_output_enable_n
);
  // ------
  // Edge discipline and cycle steps.
  // ------
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_reset);
  sequence start_seq;
    $fell(o_transfer_start_n);
  endsequence
  sequence ack_take_seq;
    !o_addr_strobe_n && !o_bus_input_clock && !i_transfer_ack_n;
  endsequence
  rise_only_a: assert property (!$stable({o_addr, o_addr_oe, o_read_write, o_transfer_size_code,
    o_transfer_type, o_transfer_modifier, o_transfer_start_n, o_transfer_in_progress_n, o_data_out,
    o_data_oe}) |-> $rose(o_bus_input_clock)) else $error("rising group moved off a rising edge");
  fall_only_a: assert property (!$stable({o_addr_strobe_n, o_chip_select_n, o_dram_select,
    o_byte_lane_enable_n, o_output_enable_n}) |-> $fell(o_bus_input_clock))
    else $error("strobe group moved off a falling edge");
  clock_half_a: assert property (1'b1 |=> $changed(o_bus_input_clock))
    else $error("bus clock did not toggle");
  start_strobe_a: assert property (start_seq |-> !o_transfer_in_progress_n ##1
    (!o_addr_strobe_n && o_byte_lane_enable_n != 4'hf)) else $error("strobe late after start");
  start_width_a: assert property (start_seq |-> ##1 !o_transfer_start_n ##1 o_transfer_start_n)
    else $error("start not one bus clock wide");
  write_drive_a: assert property (start_seq ##0 !o_read_write |-> ##2 o_data_oe)
    else $error("write data not driven");
  ack_take_a: assert property (ack_take_seq |-> ##1 !o_addr_strobe_n ##1 o_addr_strobe_n)
    else $error("strobe not negated after acknowledge");
  done_quiet_a: assert property (o_done |-> o_transfer_in_progress_n && o_addr_strobe_n &&
    !o_data_oe && !o_addr_oe && o_read_write && o_transfer_size_code == 2'h0)
    else $error("attributes held after done");
  idle_quiet_a: assert property (o_req_ready |-> o_addr_strobe_n && o_transfer_start_n &&
    o_transfer_in_progress_n && !o_data_oe && &o_chip_select_n) else $error("idle bus not quiet");
endmodule // ebce_engine_chk

bind ebce_engine ebce_engine_chk #(.NUM_CS(NUM_CS), .NUM_WIN(NUM_WIN)) ebce_engine_chk_inst (
  .i_core_clk(i_core_clk), .i_reset(i_reset), .i_transfer_ack_n(i_transfer_ack_n),
  .o_req_ready(o_req_ready), .o_done(o_done), .o_bus_input_clock(o_bus_input_clock), .o_addr(o_addr),
  .o_addr_oe(o_addr_oe), .o_read_write(o_read_write), .o_transfer_size_code(o_transfer_size_code),
  .o_transfer_type(o_transfer_type), .o_transfer_modifier(o_transfer_modifier),
  .o_transfer_start_n(o_transfer_start_n), .o_transfer_in_progress_n(o_transfer_in_progress_n),
  .o_data_out(o_data_out), .o_data_oe(o_data_oe), .o_addr_strobe_n(o_addr_strobe_n),
  .o_chip_select_n(o_chip_select_n), .o_dram_select(o_dram_select),
  .o_byte_lane_enable_n(o_byte_lane_enable_n), .o_output_enable_n(o_output_enable_n));

// ### tb/ebce_slave.sv
// Memory model on the far side of the external bus.
`timescale 1ns/100ps

module ebce_slave (
  input  wire        i_core_clk,
  input  wire        i_reset,
  input  wire        i_bus_input_clock,
  input  wire        i_transfer_start_n,
  input  wire        i_addr_strobe_n,
  input  wire        i_transfer_in_progress_n,
  input  wire [31:0] i_addr,
  input  wire [31:0] i_data_out,
  input  wire [3:0]  i_wait,
  input  wire        i_mute,
  output reg         o_transfer_ack_n,
  output reg  [31:0] o_data,
  output reg  [31:0] o_wlast,
  output reg  [31:0] o_wbytes
);
  reg  [3:0] cnt_q;
  reg        busy_q;
  wire       take = !i_addr_strobe_n && !i_bus_input_clock && !o_transfer_ack_n;
  // Answers are launched on edges that start a low bus phase, so they are settled at the sampling edge.
  always @(posedge i_core_clk) begin
    if (i_reset) begin
      busy_q <= 1'b0;
      cnt_q <= 4'h0;
      o_transfer_ack_n <= 1'b1;
      o_data <= 32'h0;
    end else if (take) begin
      o_transfer_ack_n <= 1'b1;
      o_data <= ~o_data;
      busy_q <= 1'b0;
      o_wlast <= i_data_out;
      o_wbytes <= {o_wbytes[23:0], i_data_out[31:24]};
    end else if (i_bus_input_clock && !i_transfer_start_n && !busy_q) begin
      busy_q <= 1'b1;
      cnt_q <= i_wait;
      if (i_wait == 4'h0 && !i_mute) begin
        o_transfer_ack_n <= 1'b0;
        o_data <= {i_addr[7:0] ^ 8'ha5, i_addr[23:0]};
      end
    end else if (busy_q && i_bus_input_clock && cnt_q != 4'h0) begin
      cnt_q <= cnt_q - 4'h1;
      if (cnt_q == 4'h1 && !i_mute) begin
        o_transfer_ack_n <= 1'b0;
        o_data <= {i_addr[7:0] ^ 8'ha5, i_addr[23:0]};
      end
    end else if (i_transfer_in_progress_n) begin
      busy_q <= 1'b0;
    end
  end
endmodule // ebce_slave

// ### tb/ebce_engine_bench.sv
// Self-checking bench for the external bus cycle engine.
`timescale 1ns/100ps

module ebce_engine_bench;
  reg clk, rst, req, wr, mute, bst, ts_prev;
  reg [31:0] addr, wd;
  reg [1:0] sz, tt;
  reg [2:0] tm;
  reg [3:0] wt, be_acc;
  reg [7:0] cs_acc;
  reg [159:0] base, mask;
  reg [99:0] cfg;
  reg [1:0] szq [0:15];
  reg [31:0] r;
  reg [15:0] bases [0:7];
  integer nsz, seed, miscompares, total_checks, k;
  wire rdy, done, bclk, aoe, rw, ts_n, tip_n, doe, as_n, oe_n, ack_n;
  wire [31:0] rdata, a_out, dout, din, wlast, wbytes;
  wire [1:0] siz, tt_o, dsel;
  wire [2:0] tm_o;
  wire [7:0] cs_n;
  wire [3:0] be_n;
  // ------
  // Clock, windows and instances.
  // ------
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @* begin
    base = 160'h0; mask = 160'h0; cfg = 100'h0;
    base[15:0] = 16'h1000; cfg[9:0] = 10'h200;
    base[31:16] = 16'h2000; cfg[19:10] = bst ? 10'h381 : 10'h201;
    base[47:32] = 16'h3000; mask[47:32] = 16'h0001; cfg[29:20] = 10'h202;
    base[63:48] = 16'h3001; cfg[39:30] = 10'h201;
    base[79:64] = 16'h4000; cfg[49:40] = 10'h248;
  end
  ebce_engine ebce_engine_inst (.i_core_clk(clk), .i_reset(rst), .i_req(req), .i_req_addr(addr),
    .i_req_write(wr), .i_req_size(sz), .i_req_type(tt), .i_req_modifier(tm), .i_req_wdata(wd),
    .i_win_base(base), .i_win_mask(mask), .i_win_cfg(cfg), .i_transfer_ack_n(ack_n), .i_data_in(din),
    .o_req_ready(rdy), .o_done(done), .o_rdata(rdata), .o_bus_input_clock(bclk), .o_addr(a_out),
    .o_addr_oe(aoe), .o_read_write(rw), .o_transfer_size_code(siz), .o_transfer_type(tt_o),
    .o_transfer_modifier(tm_o), .o_transfer_start_n(ts_n), .o_transfer_in_progress_n(tip_n),
    .o_data_out(dout), .o_data_oe(doe), .o_addr_strobe_n(as_n), .o_chip_select_n(cs_n),
    .o_dram_select(dsel), .o_byte_lane_enable_n(be_n), .o_output_enable_n(oe_n));
  ebce_slave ebce_slave_inst (.i_core_clk(clk), .i_reset(rst), .i_bus_input_clock(bclk),
    .i_transfer_start_n(ts_n), .i_addr_strobe_n(as_n), .i_transfer_in_progress_n(tip_n), .i_addr(a_out),
    .i_data_out(dout), .i_wait(wt), .i_mute(mute), .o_transfer_ack_n(ack_n), .o_data(din),
    .o_wlast(wlast), .o_wbytes(wbytes));
  always @(negedge clk) begin
    if (!ts_n && ts_prev) chk({aoe, rw, tt_o, tm_o}, {1'b1, !wr, tt, tm});
    if (!ts_n && ts_prev && nsz < 16) begin
      szq[nsz] = siz;
      nsz = nsz + 1;
    end
    ts_prev = ts_n;
    if (!as_n) begin
      cs_acc = cs_acc & cs_n;
      be_acc = be_acc & be_n;
    end
  end
  // ------
  // Comparison, transfer and closing tasks.
  // ------
  task chk(input [31:0] got, input [31:0] exp);
    begin
      total_checks = total_checks + 1;
      if (got !== exp) begin
        miscompares = miscompares + 1;
        $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
    end
  endtask
  task go(input [31:0] a, input w_, input [1:0] s, input [3:0] ws);
    integer pb, bt, nb, per, n, i;
    reg [1:0] pc;
    reg bu, intl;
    reg [7:0] cse;
    reg [31:0] aa, er;
    begin
      pb = 4; pc = 2'h0; bu = 1'b0; intl = 1'b0;
      case (a[31:16])
        16'h1000: cse = 8'hfe;
        16'h2000: begin cse = 8'hfd; pb = 1; pc = 2'h1; bu = bst; end
        16'h3001: cse = 8'hf3;
        16'h4000: begin cse = 8'hef; intl = 1'b1; end
        default: cse = 8'hff;
      endcase
      bt = (s == 2'h0) ? 4 : (s == 2'h1) ? 1 : (s == 2'h2) ? 2 : 16;
      nb = (bt > pb) ? bt / pb : 1;
      per = intl ? 10 : (ws == 4'h0) ? 4 : 4 + 2 * ws;
      aa = a & ~(bt - 1);
      @(negedge clk);
      addr = aa; wr = w_; sz = s; wt = ws; mute = intl; wd = $random(seed); tt = wd[1:0]; tm = wd[4:2];
      req = 1'b1; nsz = 0; cs_acc = 8'hff; be_acc = 4'hf; n = 0;
      while (rdy !== 1'b1 && n < 100) begin @(negedge clk); n = n + 1; end
      n = 0;
      do begin @(negedge clk); n = n + 1; req = 1'b0; end while (done !== 1'b1 && n < 400);
      chk(n - 1, nb * per);
      chk(nsz, nb);
      for (i = 0; i < nsz; i = i + 1) chk(szq[i], (i == 0 || bu) ? s : pc);
      chk(cs_acc, cse);
      if (s == 2'h0) chk(be_acc, (pb == 1) ? 4'he : 4'h0);
      er = {aa[7:0] ^ 8'ha5, aa[23:0]};
      if (pb == 1) for (i = 0; i < 4; i = i + 1) er = {er[23:0], (aa[7:0] + i[7:0]) ^ 8'ha5};
      if (s == 2'h0 && !intl && !w_) chk(rdata, er);
      if (s == 2'h0 && !intl && w_) chk((pb == 1) ? wbytes : wlast, wd);
    end
  endtask
  task test_done;
    begin
      $display("checks %0d mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
    end
  endtask
  // ------
  // Main sequence; random traffic follows the hand-picked awkward cases.
  // ------
  initial begin
    seed = 57; miscompares = 0; total_checks = 0; rst = 1'b1; req = 1'b0; addr = 32'h0; wr = 1'b0;
    sz = 2'h0; tt = 2'h0; tm = 3'h0; wd = 32'h0; wt = 4'h0; mute = 1'b0; bst = 1'b0; ts_prev = 1'b1;
    nsz = 0; cs_acc = 8'hff; be_acc = 4'hf;
    bases[0] = 16'h1000; bases[1] = 16'h2000; bases[2] = 16'h3001; bases[3] = 16'h4000;
    bases[4] = 16'h5000; bases[5] = 16'h1000; bases[6] = 16'h2000; bases[7] = 16'h2000;
    repeat (16) @(negedge clk);
    rst = 1'b0;
    go(32'h20000000, 1'b0, 2'h0, 4'h0);
    bst = 1'b1;
    go(32'h20000010, 1'b1, 2'h0, 4'h1);
    go(32'h20000022, 1'b0, 2'h2, 4'h0);
    go(32'h10000040, 1'b0, 2'h3, 4'h2);
    go(32'h10000003, 1'b1, 2'h1, 4'h1);
    go(32'h30010000, 1'b0, 2'h0, 4'h1);
    go(32'h50000000, 1'b1, 2'h0, 4'h3);
    go(32'h40000000, 1'b0, 2'h0, 4'h0);
    go(32'h40000004, 1'b1, 2'h0, 4'h0);
    rst = 1'b1;
    repeat (3) @(negedge clk);
    rst = 1'b0;
    for (k = 0; k < 40; k = k + 1) begin
      r = $random(seed);
      bst = r[20];
      go({bases[r[2:0]], r[31:16]}, r[3], r[5:4], {2'h0, r[7:6]});
    end
    test_done;
  end
  initial begin
    #1000000;
    miscompares = miscompares + 1;
    test_done;
  end
endmodule // ebce_engine_bench
